// ### devcap_link_partner.sv
/*
  Upstream link partner model: issues power limit messages on request
  and whenever the link comes up while rst_n is high. Assumes the bench drives its controls
  just after rising edges of sys_clk.
*/
`timescale 1ns/1ps
`default_nettype none
module devcap_link_partner (
  // clock and reset
  input wire logic sys_clk,
  input wire logic rst_n,
  // bench control
  input wire logic link_up,
  input wire logic send_req,
  input wire logic [7:0] limit_value,
  input wire logic [1:0] limit_scale,
  // message out
  output logic msg_valid,
  output logic [7:0] msg_value,
  output logic [1:0] msg_scale
);
  // ------------------------------------------------------------
  // message issue
  // ------------------------------------------------------------
  logic link_up_q;
  logic fire;
  assign fire = rst_n && (send_req || (link_up && !link_up_q));
  always_ff @(posedge sys_clk) begin
    link_up_q <= link_up;
    msg_valid <= fire;
    // idle data toggles while rst_n is high so a stale value never passes for a message
    if (fire) begin
      msg_value <= limit_value;
      msg_scale <= limit_scale;
    end else begin
      msg_value <= rst_n ? ~msg_value : 8'h5a;
      msg_scale <= rst_n ? ~msg_scale : 2'h1;
    end
  end
endmodule
`default_nettype wire

// ### devcap_pkg.sv
/*
  Package for the device capabilities register block: offsets, field
  positions, reset values, port type codes and power limit scale codes.
  Assumes a 32-bit APB register bus with one aligned word per register.
*/
package devcap_pkg;

  // ------------------------------------------------------------
  // register map
  // ------------------------------------------------------------
  localparam logic [11:0] devcap_offset = 12'h044;
  localparam logic [11:0] lock_ctrl_offset = 12'h100;

  // ------------------------------------------------------------
  // field positions
  // ------------------------------------------------------------
  localparam int mps_lsb = 0;
  localparam int mps_msb = 2;
  localparam int pfs_lsb = 3;
  localparam int pfs_msb = 4;
  localparam int extended_tag_support_bit = 5;
  localparam int l0s_lsb = 6;
  localparam int l0s_msb = 8;
  localparam int l1_lsb = 9;
  localparam int l1_msb = 11;
  localparam int abp_bit = 12;
  localparam int aip_bit = 13;
  localparam int pip_bit = 14;
  localparam int rber_bit = 15;
  localparam int plv_lsb = 18;
  localparam int plv_msb = 25;
  localparam int pls_lsb = 26;
  localparam int pls_msb = 27;

  // ------------------------------------------------------------
  // reset and fixed values
  // ------------------------------------------------------------
  localparam logic [2:0] mps_reset = 3'h4;
  localparam logic extended_tag_support_reset = 1'h1;
  localparam logic rber_value = 1'h1;
  localparam logic [7:0] plv_reset = 8'h00;
  localparam logic [1:0] pls_reset = 2'h0;
  localparam logic lock_reset = 1'h0;

  // ------------------------------------------------------------
  // port type codes and scale encodings
  // ------------------------------------------------------------
  localparam logic [3:0] port_type_upstream = 4'h5;
  localparam logic [3:0] port_type_downstream = 4'h6;

  typedef enum logic [1:0] {
    scale_1p0 = 2'b00,
    scale_0p1 = 2'b01,
    scale_0p01 = 2'b10,
    scale_0p001 = 2'b11
  } power_scale_e;

endpackage

// ### devcap_power_capture.sv
/*
  Captures slot power limit value and scale from a received power
  limit message. Assumes msg_valid is a one-cycle pulse synchronous
  to sys_clk with its data valid in the same cycle.
*/
`timescale 1ns/1ps
`default_nettype none
module devcap_power_capture (
  // clock and reset
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic clk_en,
  // port role
  input wire logic [3:0] port_type,
  // message
  input wire logic msg_valid,
  input wire logic [7:0] msg_value,
  input wire logic [1:0] msg_scale,
  // captured fields
  output logic [7:0] captured_power_limit_value,
  output logic [1:0] captured_power_limit_scale
);

  logic is_upstream;

  assign is_upstream = (port_type == devcap_pkg::port_type_upstream);

  // ------------------------------------------------------------
  // capture
  // ------------------------------------------------------------
  // a downstream port clears on every cycle with clk_en high so a role change cannot leave stale data
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      captured_power_limit_value <= devcap_pkg::plv_reset;
      captured_power_limit_scale <= devcap_pkg::pls_reset;
    end else if (clk_en) begin
      if (!is_upstream) begin
        captured_power_limit_value <= devcap_pkg::plv_reset;
        captured_power_limit_scale <= devcap_pkg::pls_reset;
      end else if (msg_valid) begin
        captured_power_limit_value <= msg_value;
        captured_power_limit_scale <= msg_scale;
      end
    end
  end

  // ------------------------------------------------------------
  // checks
  // ------------------------------------------------------------
  a_downstream_zero: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (clk_en && port_type != 4'h5) |=> (captured_power_limit_value == 8'h00
    && captured_power_limit_scale == 2'h0))
    else $error("downstream port holds nonzero power limit");

  a_value_capture: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (clk_en && port_type == 4'h5 && msg_valid)
    |=> (captured_power_limit_value == $past(msg_value)))
    else $error("power limit value not captured");

  a_scale_capture: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (clk_en && port_type == 4'h5 && msg_valid)
    |=> (captured_power_limit_scale == $past(msg_scale)))
    else $error("power limit scale not captured");

  a_upstream_code: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (clk_en && port_type == 4'h5 && !msg_valid)
    |=> ($stable(captured_power_limit_value) && $stable(captured_power_limit_scale)))
    else $error("upstream power limit changed without a message");

endmodule
`default_nettype wire

// ### devcap_regs.sv
/*
  Device capabilities register for one switch port, reached over APB.
  Assumes an APB master on sys_clk, a synchronous active-low reset and
  a message decoder that pulses msg_valid for each power limit message.
*/
`timescale 1ns/1ps
`default_nettype none
module devcap_regs (
  // clock and reset
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic clk_en,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // port role
  input wire logic [3:0] port_type,
  // power limit message
  input wire logic msg_valid,
  input wire logic [7:0] msg_value,
  input wire logic [1:0] msg_scale,
  // field view
  output logic [31:0] device_capabilities
);

  logic [2:0] max_payload_supported;
  logic extended_tag_support;
  logic write_lock;
  logic [7:0] captured_power_limit_value;
  logic [1:0] captured_power_limit_scale;
  logic access;
  logic wr_en;
  logic unmapped;

  // ------------------------------------------------------------
  // decode
  // ------------------------------------------------------------
  function automatic logic hit(input logic [11:0] a, input logic [11:0] off);
    hit = (a[11:2] == off[11:2]);
  endfunction

  assign access = psel && penable && clk_en;
  assign wr_en = access && pwrite;
  assign unmapped = !hit(paddr, devcap_pkg::devcap_offset)
    && !hit(paddr, devcap_pkg::lock_ctrl_offset);
  // zero wait states; held off while the clock enable is low
  assign pready = clk_en;
  assign pslverr = psel && penable && unmapped;

  // ------------------------------------------------------------
  // register image
  // ------------------------------------------------------------
  always_comb begin
    device_capabilities = 32'h0000_0000;
    device_capabilities[devcap_pkg::mps_msb:devcap_pkg::mps_lsb] = max_payload_supported;
    device_capabilities[devcap_pkg::extended_tag_support_bit] = extended_tag_support;
    device_capabilities[devcap_pkg::rber_bit] = devcap_pkg::rber_value;
    device_capabilities[devcap_pkg::plv_msb:devcap_pkg::plv_lsb] =
      captured_power_limit_value;
    device_capabilities[devcap_pkg::pls_msb:devcap_pkg::pls_lsb] =
      captured_power_limit_scale;
  end

  // ------------------------------------------------------------
  // lockable fields
  // ------------------------------------------------------------
  // once locked, the payload size and extended tag fields stay until reset
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      write_lock <= devcap_pkg::lock_reset;
    end else if (wr_en && hit(paddr, devcap_pkg::lock_ctrl_offset) && pstrb[0]) begin
      write_lock <= write_lock | pwdata[0];
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      max_payload_supported <= devcap_pkg::mps_reset;
      extended_tag_support <= devcap_pkg::extended_tag_support_reset;
    end else if (wr_en && hit(paddr, devcap_pkg::devcap_offset) && !write_lock
                 && pstrb[0]) begin
      max_payload_supported <= pwdata[devcap_pkg::mps_msb:devcap_pkg::mps_lsb];
      extended_tag_support <= pwdata[devcap_pkg::extended_tag_support_bit];
    end
  end

  // ------------------------------------------------------------
  // read data
  // ------------------------------------------------------------
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      prdata <= 32'h0000_0000;
    end else if (clk_en && psel && !penable && !pwrite) begin
      if (hit(paddr, devcap_pkg::devcap_offset)) begin
        prdata <= device_capabilities;
      end else if (hit(paddr, devcap_pkg::lock_ctrl_offset)) begin
        prdata <= {31'h0, write_lock};
      end else begin
        prdata <= 32'h0000_0000;
      end
    end
  end

  // ------------------------------------------------------------
  // power limit capture
  // ------------------------------------------------------------
  devcap_power_capture u_capture (
    .sys_clk(sys_clk),
    .rst_n(rst_n),
    .clk_en(clk_en),
    .port_type(port_type),
    .msg_valid(msg_valid),
    .msg_value(msg_value),
    .msg_scale(msg_scale),
    .captured_power_limit_value(captured_power_limit_value),
    .captured_power_limit_scale(captured_power_limit_scale)
  );

  // ------------------------------------------------------------
  // checks
  // ------------------------------------------------------------
  a_fixed_zero_bits: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (device_capabilities[14:6] == 9'h000 && device_capabilities[4:3] == 2'h0))
    else $error("hardwired zero fields not zero");

  a_reserved_zero: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (device_capabilities[17:16] == 2'h0 && device_capabilities[31:28] == 4'h0))
    else $error("reserved bits not zero");

  a_role_error_set: assert property (@(posedge sys_clk) disable iff (!rst_n)
    device_capabilities[15])
    else $error("role based error bit clear");

  a_payload_reset: assert property (@(posedge sys_clk)
    !rst_n |=> (device_capabilities[2:0] == 3'h4 && device_capabilities[5]))
    else $error("payload or tag reset value wrong");

  a_locked_hold: assert property (@(posedge sys_clk) disable iff (!rst_n)
    write_lock |=> $stable(device_capabilities[5:0]))
    else $error("locked field changed");

  a_payload_write: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (wr_en && hit(paddr, devcap_pkg::devcap_offset) && !write_lock && pstrb[0])
    |=> (device_capabilities[2:0] == $past(pwdata[2:0])
    && device_capabilities[5] == $past(pwdata[5])))
    else $error("payload write not taken");

  a_latency_zero: assert property (@(posedge sys_clk) disable iff (!rst_n)
    wr_en |=> (device_capabilities[11:6] == 6'h00))
    else $error("latency field took a write");

  a_indicators_zero: assert property (@(posedge sys_clk) disable iff (!rst_n)
    wr_en |=> (device_capabilities[14:12] == 3'h0))
    else $error("indicator presence bits set");

  a_no_write_hold: assert property (@(posedge sys_clk) disable iff (!rst_n)
    !(wr_en && hit(paddr, devcap_pkg::devcap_offset))
    |=> $stable(device_capabilities[5:0]))
    else $error("writable field changed without a write");

  a_strobe_gate: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (wr_en && !pstrb[0])
    |=> $stable(device_capabilities[5:0]))
    else $error("write without low byte strobe changed a field");

  a_lock_sticky: assert property (@(posedge sys_clk) disable iff (!rst_n)
    write_lock
    |=> write_lock)
    else $error("write lock released without reset");

  // ------------------------------------------------------------
  // bus and capture checks
  // ------------------------------------------------------------
  // the clock enable must hold every field, captured ones included
  a_freeze_all: assert property (@(posedge sys_clk) disable iff (!rst_n)
    !clk_en
    |=> $stable(device_capabilities))
    else $error("register image changed while clock enable low");

  a_read_image: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (clk_en && psel && !penable && !pwrite && hit(paddr, devcap_pkg::devcap_offset))
    |=> (prdata == $past(device_capabilities)))
    else $error("read data differs from register image");

  a_read_lock: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (clk_en && psel && !penable && !pwrite && hit(paddr, devcap_pkg::lock_ctrl_offset))
    |=> (prdata == {31'h0, $past(write_lock)}))
    else $error("lock read data wrong");

  a_unmapped_read: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (clk_en && psel && !penable && !pwrite && unmapped)
    |=> (prdata == 32'h0000_0000))
    else $error("unmapped read returned nonzero data");

  a_upstream_view: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (clk_en && port_type == 4'h5 && msg_valid)
    |=> (device_capabilities[25:18] == $past(msg_value)
    && device_capabilities[27:26] == $past(msg_scale)))
    else $error("power limit message not visible in register");

  a_downstream_view: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (clk_en && port_type != 4'h5)
    |=> (device_capabilities[27:18] == 10'h000))
    else $error("downstream register shows a power limit");

endmodule
`default_nettype wire

// ### test_pcie_device_capabilities_reg.sv
/*
  Self-checking bench for the device capabilities register.
  Assumes devcap_regs as the design and the link partner model.
*/
`timescale 1ns/1ps
`default_nettype none
module test_pcie_device_capabilities_reg;
  // ------------------------------------------------------------
  // signals and instances
  // ------------------------------------------------------------
  logic sys_clk, rst_n, clk_en, psel, penable, pwrite, pready, pslverr, err;
  logic msg_valid, link_up, send_req;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, device_capabilities, rd;
  logic [3:0] pstrb, port_type;
  logic [7:0] msg_value, lim_v;
  logic [1:0] msg_scale, lim_s;
  int num_errors, checks;
  localparam logic [11:0] dc = devcap_pkg::devcap_offset;
  devcap_regs i_dut (.sys_clk(sys_clk), .rst_n(rst_n), .clk_en(clk_en), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .port_type(port_type),
    .msg_valid(msg_valid), .msg_value(msg_value), .msg_scale(msg_scale),
    .device_capabilities(device_capabilities));
  devcap_link_partner i_partner (.sys_clk(sys_clk), .rst_n(rst_n), .link_up(link_up),
    .send_req(send_req), .limit_value(lim_v), .limit_scale(lim_s),
    .msg_valid(msg_valid), .msg_value(msg_value), .msg_scale(msg_scale));
  always #2.5 sys_clk = ~sys_clk;
  // ------------------------------------------------------------
  // shared tasks
  // ------------------------------------------------------------
  function automatic logic [31:0] img(input logic [2:0] m, input logic e,
      input logic [7:0] v, input logic [1:0] s);
    return {4'h0, s, v, 2'h0, 1'h1, 9'h000, e, 2'h0, m};
  endfunction
  task check(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("Error %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  task apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    psel <= 1'b1; penable <= 1'b0; pwrite <= wr; paddr <= a; pwdata <= d;
    @(posedge sys_clk);
    penable <= 1'b1;
    // wait for the slave; only the watchdog ends a hang
    do begin
      @(posedge sys_clk);
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0; penable <= 1'b0;
  endtask
  task do_reset;
    rst_n <= 1'b0;
    repeat (20) @(posedge sys_clk);
    rst_n <= 1'b1;
  endtask
  task send_msg(input logic [7:0] v, input logic [1:0] s);
    @(posedge sys_clk);
    send_req <= 1'b1; lim_v <= v; lim_s <= s;
    @(posedge sys_clk);
    send_req <= 1'b0;
    repeat (2) @(posedge sys_clk);
  endtask
  // ------------------------------------------------------------
  // scenarios
  // ------------------------------------------------------------
  task t_reset_values;
    apb(1'b0, dc, 32'h0);
    check(rd, img(3'h4, 1'b1, 8'h00, 2'h0));
    check({31'h0, err}, 32'h0);
    check(device_capabilities, img(3'h4, 1'b1, 8'h00, 2'h0));
    $display("done reset values");
  endtask
  task t_write_fields;
    apb(1'b1, dc, 32'hffff_ffff);
    apb(1'b0, dc, 32'h0);
    check(rd, img(3'h7, 1'b1, 8'h00, 2'h0));
    apb(1'b1, dc, 32'h0);
    apb(1'b0, dc, 32'h0);
    check(rd, img(3'h0, 1'b0, 8'h00, 2'h0));
    pstrb <= 4'h0;
    apb(1'b1, dc, 32'h25);
    pstrb <= 4'hf;
    apb(1'b0, dc, 32'h0);
    check(rd, img(3'h0, 1'b0, 8'h00, 2'h0));
    apb(1'b1, dc, 32'h24);
    // the write lands at the access edge; look one edge later
    @(posedge sys_clk);
    check(device_capabilities, img(3'h4, 1'b1, 8'h00, 2'h0));
    $display("done write fields");
  endtask
  task t_unmapped;
    apb(1'b1, 12'h200, 32'hffff_ffff);
    apb(1'b0, 12'h200, 32'h0);
    check(rd, 32'h0);
    check({31'h0, err}, 32'h1);
    check(device_capabilities, img(3'h4, 1'b1, 8'h00, 2'h0));
    $display("done unmapped");
  endtask
  task t_capture_up;
    for (int i = 0; i < 4; i++) begin
      send_msg(8'hff - 8'(i * 64), 2'(i));
      check(device_capabilities, img(3'h4, 1'b1, 8'hff - 8'(i * 64), 2'(i)));
    end
    apb(1'b0, dc, 32'h0);
    check(rd, img(3'h4, 1'b1, 8'h3f, 2'h3));
    lim_v <= 8'h19; lim_s <= 2'h1; link_up <= 1'b1;
    repeat (4) @(posedge sys_clk);
    check(device_capabilities, img(3'h4, 1'b1, 8'h19, 2'h1));
    $display("done upstream capture");
  endtask
  task t_downstream;
    port_type <= devcap_pkg::port_type_downstream;
    repeat (2) @(posedge sys_clk);
    check(device_capabilities, img(3'h4, 1'b1, 8'h00, 2'h0));
    send_msg(8'haa, 2'h3);
    check(device_capabilities, img(3'h4, 1'b1, 8'h00, 2'h0));
    port_type <= devcap_pkg::port_type_upstream;
    send_msg(8'h55, 2'h2);
    check(device_capabilities, img(3'h4, 1'b1, 8'h55, 2'h2));
    port_type <= 4'h0;
    send_msg(8'h33, 2'h1);
    check(device_capabilities, img(3'h4, 1'b1, 8'h00, 2'h0));
    port_type <= devcap_pkg::port_type_upstream;
    $display("done downstream");
  endtask
  task t_clk_en;
    send_msg(8'h66, 2'h2);
    check(device_capabilities, img(3'h4, 1'b1, 8'h66, 2'h2));
    clk_en <= 1'b0;
    send_msg(8'h11, 2'h1);
    check(device_capabilities, img(3'h4, 1'b1, 8'h66, 2'h2));
    check({31'h0, pready}, 32'h0);
    clk_en <= 1'b1;
    send_msg(8'h11, 2'h1);
    check(device_capabilities, img(3'h4, 1'b1, 8'h11, 2'h1));
    $display("done clock enable");
  endtask
  task t_lock;
    apb(1'b1, devcap_pkg::lock_ctrl_offset, 32'h1);
    apb(1'b0, devcap_pkg::lock_ctrl_offset, 32'h0);
    check(rd & 32'h1, 32'h1);
    apb(1'b1, dc, 32'h0);
    apb(1'b0, dc, 32'h0);
    check(rd, img(3'h4, 1'b1, 8'h11, 2'h1));
    do_reset;
    apb(1'b0, devcap_pkg::lock_ctrl_offset, 32'h0);
    check(rd & 32'h1, 32'h0);
    apb(1'b1, dc, 32'h0);
    @(posedge sys_clk);
    check(device_capabilities, img(3'h0, 1'b0, 8'h00, 2'h0));
    $display("done lock");
  endtask
  // ------------------------------------------------------------
  // run control
  // ------------------------------------------------------------
  task wrap_up;
    $display("checks %0d mismatches %0d", checks, num_errors);
    if (num_errors == 0 && checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  initial begin
    sys_clk = 0; rst_n = 0; clk_en = 1; psel = 0; penable = 0; pwrite = 0;
    paddr = 0; pwdata = 0; pstrb = 4'hf; port_type = devcap_pkg::port_type_upstream;
    link_up = 0; send_req = 0; lim_v = 0; lim_s = 0; num_errors = 0; checks = 0;
    do_reset;
    t_reset_values;
    t_write_fields;
    t_unmapped;
    t_capture_up;
    t_downstream;
    t_clk_en;
    t_lock;
    wrap_up;
  end
  initial begin
    repeat (20000) @(posedge sys_clk);
    num_errors++;
    wrap_up;
  end
endmodule
`default_nettype wire
